// ==== rtl/rsv_regs.sv ====
// Purpose: Second-channel link status, transmit output level control and
//          per-channel equalizer result registers.
// Assumes: Configuration port access is synchronous to i_sys_clk; event
//          inputs are one-cycle pulses from the training and eq engines.
// Notes:   Reads answer one cycle after the read strobe.
//          Only the level register takes writes; status and result
//          registers are loaded by hardware alone, so writes there drop.
`default_nettype none

// What this block does
// - Top status bit shows short or long eq
// - Short/long flag held zero while eq disabled
// - Bit 3 mirrors compliance mode, resets zero
// - Bit 2 set on entering U0
// - Bit 1 set on entering U2 or U3
// - Bit 0 disconnect flag, resets to one
// - Bits 7-6 pick level during LFPS
// - Level code 0 highest, 3 lowest
// - Bits 3-2 set connector output level
// - Bits 1-0 set host output level
// - Limiting mode turns bits 1-0 into swing
// - Eq result shows code after full run
// - Eq result shows code applied by fast run
// - Eq result reflects the software override
module rsv_regs (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Configuration port
    input wire logic [7:0] i_cfg_addr,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_wdata,
    output logic [7:0] o_cfg_rdata,
    output logic o_cfg_rvalid,
    output logic o_cfg_hit,
    // Eq control owned by other registers
    input wire logic i_adaptive_eq_enable,
    input wire logic [1:0] i_adaptive_eq_algorithm_select,
    input wire logic i_eq_override_enable,
    input wire logic [rsv_pkg::RSV_EQ_W-1:0] i_eq_override_value,
    // Engine events
    input wire rsv_pkg::rsv_link_evt_type i_ch2_link,
    input wire rsv_pkg::rsv_eq_evt_type i_ch1_eq,
    input wire rsv_pkg::rsv_eq_evt_type i_ch2_eq,
    // Transmit driver control
    input wire logic i_host_tx_limiting_enable,
    input wire logic i_lfps_active,
    output rsv_pkg::rsv_levels_type o_levels,
    output logic [3:0] o_connector_level_onehot,
    output logic [3:0] o_host_level_onehot,
    output logic o_host_tx_limiting,
    output logic [1:0] o_host_swing_level,
    // Status seen by the rest of the chip
    output logic [7:0] o_ch2_link_status,
    output logic [rsv_pkg::RSV_EQ_W-1:0] o_ch1_chosen_eq_code,
    output logic [rsv_pkg::RSV_EQ_W-1:0] o_ch2_chosen_eq_code
);
    import rsv_pkg::*;

    // One-hot strength of a level code; bit 3 is the highest level
    // Drivers want one select line per level, not a binary code; the
    // default arm sends any stray code to the lowest, gentlest level.
    function automatic logic [3:0] level_onehot(input logic [1:0] lvl);
        logic [3:0] oh;
        oh = 4'h0;
        case (lvl)
            RSV_LIN_HIGHEST: oh = 4'h8;
            RSV_LIN_SECOND: oh = 4'h4;
            RSV_LIN_THIRD: oh = 4'h2;
            default: oh = 4'h1;
        endcase
        return oh;
    endfunction

    // Address match used for both reads and writes
    // Hit reports writes too, so software can tell a write to a
    // read-only offset from a write to an address nobody answers.
    function automatic logic is_mapped(input logic [7:0] a);
        logic hit;
        hit = 1'b0;
        if (a == RSV_OFS_CH2_LINK_STATUS) begin
            hit = 1'b1;
        end else if (a == RSV_OFS_OUTPUT_LEVEL) begin
            hit = 1'b1;
        end else if (a == RSV_OFS_CH1_EQ_RESULT) begin
            hit = 1'b1;
        end else if (a == RSV_OFS_CH2_EQ_RESULT) begin
            hit = 1'b1;
        end
        return hit;
    endfunction

    // Status flags of the second channel
    // One flop per flag keeps each set and clear term readable
    logic fast_long_q;
    logic compliance_q;
    logic active_q;
    logic low_power_q;
    logic disc_q;
    logic fast_eq_allowed;

    // Output level register fields
    logic [1:0] lfps_lvl_q;
    logic [1:0] conn_lvl_q;
    logic [1:0] host_lvl_q;
    logic wr_level;

    // Per-channel chosen code and reported code
    // Unpacked by channel so the generate loop below can index them
    logic [RSV_EQ_W-1:0] chosen_q [RSV_NUM_CH];
    logic [RSV_EQ_W-1:0] report_q [RSV_NUM_CH];
    rsv_eq_evt_type eq_evt [RSV_NUM_CH];

    // Read path
    logic [7:0] rdata_d;
    logic [7:0] link_status;
    logic [7:0] level_reg;

    assign eq_evt[0] = i_ch1_eq;
    assign eq_evt[1] = i_ch2_eq;

    // The flag only means something with the engine on and mode x0
    // Select values with bit 0 set run a search that has no short or
    // long outcome, so the flag is masked for them.
    assign fast_eq_allowed = i_adaptive_eq_enable
        && !i_adaptive_eq_algorithm_select[RSV_ALG_SEL_BIT];

    // Short/long result of the last fast run on the second channel
    // Disable wins over a same-cycle fast result: the flag must read
    // zero while the engine is off and stay zero when it comes back
    // on, until a new fast run reports.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fast_long_q <= 1'b0;
        end else if (!i_adaptive_eq_enable) begin
            fast_long_q <= 1'b0;
        end else if (i_ch2_eq.fast_applied && fast_eq_allowed) begin
            fast_long_q <= i_ch2_eq.fast_long;
        end
    end

    // Compliance flag follows the training logic level
    // One flop of lag keeps the status byte registered; the level is
    // long-lived, so software never sees the delay.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            compliance_q <= 1'b0;
        end else begin
            compliance_q <= i_ch2_link.compliance;
        end
    end

    // State flags: set on entry, dropped when another state is entered.
    // Set is tested first so a same-cycle entry is never lost.
    // Two entries in one cycle leave both flags set rather than
    // guess which came last.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            active_q <= 1'b0;
        end else if (i_ch2_link.enter_active) begin
            active_q <= 1'b1;
        end else if (i_ch2_link.enter_low_pwr || i_ch2_link.enter_disc) begin
            active_q <= 1'b0;
        end
    end

    // One flag covers U2 and U3; software cannot tell them apart
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            low_power_q <= 1'b0;
        end else if (i_ch2_link.enter_low_pwr) begin
            low_power_q <= 1'b1;
        end else if (i_ch2_link.enter_active || i_ch2_link.enter_disc) begin
            low_power_q <= 1'b0;
        end
    end

    // Out of reset the link counts as disconnected
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            disc_q <= RSV_RST_CH2_LINK_STATUS[RSV_BIT_DISCONNECT];
        end else if (i_ch2_link.enter_disc) begin
            disc_q <= 1'b1;
        end else if (i_ch2_link.enter_active || i_ch2_link.enter_low_pwr) begin
            disc_q <= 1'b0;
        end
    end

    // Assembled status byte; reserved bits 6-4 read as zero
    // Bit 7 is masked, not cleared, so a short switch of algorithm
    // select does not lose the stored result.
    always_comb begin
        link_status = 8'h00;
        link_status[RSV_BIT_FAST_EQ_LONG] = fast_long_q && fast_eq_allowed;
        link_status[RSV_BIT_COMPLIANCE] = compliance_q;
        link_status[RSV_BIT_ACTIVE] = active_q;
        link_status[RSV_BIT_LOW_POWER] = low_power_q;
        link_status[RSV_BIT_DISCONNECT] = disc_q;
    end

    // Output level register, the only one software may write
    // Full-byte compare, so no alias of the offset can reach it
    assign wr_level = i_cfg_wr && (i_cfg_addr == RSV_OFS_OUTPUT_LEVEL);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lfps_lvl_q <= RSV_RST_OUTPUT_LEVEL[RSV_LFPS_LSB +: RSV_LEVEL_W];
            conn_lvl_q <= RSV_RST_OUTPUT_LEVEL[RSV_CONN_LSB +: RSV_LEVEL_W];
            host_lvl_q <= RSV_RST_OUTPUT_LEVEL[RSV_HOST_LSB +: RSV_LEVEL_W];
        end else if (wr_level) begin
            lfps_lvl_q <= i_cfg_wdata[RSV_LFPS_LSB +: RSV_LEVEL_W];
            conn_lvl_q <= i_cfg_wdata[RSV_CONN_LSB +: RSV_LEVEL_W];
            host_lvl_q <= i_cfg_wdata[RSV_HOST_LSB +: RSV_LEVEL_W];
        end
    end

    // Bits 5-4 are reserved and never stored
    // so a write of ones there cannot leak into a later read
    always_comb begin
        level_reg = 8'h00;
        level_reg[RSV_LFPS_LSB +: RSV_LEVEL_W] = lfps_lvl_q;
        level_reg[RSV_CONN_LSB +: RSV_LEVEL_W] = conn_lvl_q;
        level_reg[RSV_HOST_LSB +: RSV_LEVEL_W] = host_lvl_q;
    end

    // Per-channel equalizer result. The engine code is stored on either
    // kind of run; the override is folded in at report time so a change
    // of override shows without waiting for a new run.
    // The cost is one extra cycle before a result reaches software,
    // small beside the length of any equalizer run.
    for (genvar ch = 0; ch < RSV_NUM_CH; ch++) begin : g_eq
        always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                chosen_q[ch] <= RSV_RST_EQ_RESULT[RSV_EQ_W-1:0];
            end else if (eq_evt[ch].full_done) begin
                chosen_q[ch] <= eq_evt[ch].code;
            end else if (eq_evt[ch].fast_applied) begin
                chosen_q[ch] <= eq_evt[ch].code;
            end
        end

        always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
                report_q[ch] <= RSV_RST_EQ_RESULT[RSV_EQ_W-1:0];
            end else if (i_eq_override_enable) begin
                report_q[ch] <= i_eq_override_value;
            end else begin
                report_q[ch] <= chosen_q[ch];
            end
        end
    end

    // Read decode; unmapped offsets read zero
    // Built from stored state and the live eq mask only, so a read in the cycle of a write
    // returns the value from before that write.
    always_comb begin
        rdata_d = 8'h00;
        if (i_cfg_addr == RSV_OFS_CH2_LINK_STATUS) begin
            rdata_d = link_status;
        end else if (i_cfg_addr == RSV_OFS_OUTPUT_LEVEL) begin
            rdata_d = level_reg;
        end else if (i_cfg_addr == RSV_OFS_CH1_EQ_RESULT) begin
            rdata_d = {{(8 - RSV_EQ_W){1'b0}}, report_q[0]};
        end else if (i_cfg_addr == RSV_OFS_CH2_EQ_RESULT) begin
            rdata_d = {{(8 - RSV_EQ_W){1'b0}}, report_q[1]};
        end
    end

    // Read answer one cycle after the strobe, held until the next read
    // Holding the byte lets a slow serial engine collect it late
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg_rdata <= 8'h00;
        end else if (i_cfg_rd) begin
            o_cfg_rdata <= rdata_d;
        end
    end

    // Valid and hit pulse with the answer
    // Hit follows writes as well, one cycle after the strobe
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_cfg_rvalid <= 1'b0;
            o_cfg_hit <= 1'b0;
        end else begin
            o_cfg_rvalid <= i_cfg_rd;
            o_cfg_hit <= (i_cfg_rd || i_cfg_wr) && is_mapped(i_cfg_addr);
        end
    end

    // Driver settings. During LFPS both one-hot selects use the LFPS level;
    // in limiting mode the host level field is a swing, not linearity.
    // LFPS is tested first because its bursts need the LFPS level on
    // both one-hot selects, limiting or not. Registered so the analog selects
    // never see a decode glitch.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_levels <= rsv_levels_type'({RSV_RST_OUTPUT_LEVEL[7:6],
                RSV_RST_OUTPUT_LEVEL[3:2], RSV_RST_OUTPUT_LEVEL[1:0]});
            o_connector_level_onehot <= 4'h8;
            o_host_level_onehot <= 4'h8;
            o_host_tx_limiting <= 1'b0;
            o_host_swing_level <= 2'h0;
        end else begin
            o_levels.lfps <= rsv_level_type'(lfps_lvl_q);
            o_levels.connector <= rsv_level_type'(conn_lvl_q);
            o_levels.host <= rsv_level_type'(host_lvl_q);
            o_connector_level_onehot <= level_onehot(
                i_lfps_active ? lfps_lvl_q : conn_lvl_q);
            if (i_lfps_active) begin
                o_host_level_onehot <= level_onehot(lfps_lvl_q);
            end else if (i_host_tx_limiting_enable) begin
                o_host_level_onehot <= 4'h0;
            end else begin
                o_host_level_onehot <= level_onehot(host_lvl_q);
            end
            o_host_tx_limiting <= i_host_tx_limiting_enable;
            o_host_swing_level <= i_host_tx_limiting_enable
                ? host_lvl_q : 2'h0;
        end
    end

    // Status copies for the rest of the chip
    // They lag the readable registers by one cycle; a consumer that
    // compares both must allow for that.
    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_ch2_link_status <= RSV_RST_CH2_LINK_STATUS;
            o_ch1_chosen_eq_code <= RSV_RST_EQ_RESULT[RSV_EQ_W-1:0];
            o_ch2_chosen_eq_code <= RSV_RST_EQ_RESULT[RSV_EQ_W-1:0];
        end else begin
            o_ch2_link_status <= link_status;
            o_ch1_chosen_eq_code <= report_q[0];
            o_ch2_chosen_eq_code <= report_q[1];
        end
    end

endmodule

`default_nettype wire

// ==== pkg/rsv_pkg.sv ====
// Purpose: Shared constants and types for the redriver status and
//          output-level register group.
// Assumes: 8-bit registers on an 8-bit configuration port.
// Notes:   Offsets are byte addresses on the configuration port.
`default_nettype none

package rsv_pkg;

    // Register offsets
    localparam logic [7:0] RSV_OFS_CH2_LINK_STATUS = 8'h25;
    localparam logic [7:0] RSV_OFS_OUTPUT_LEVEL = 8'h32;
    localparam logic [7:0] RSV_OFS_CH1_EQ_RESULT = 8'h3b;
    localparam logic [7:0] RSV_OFS_CH2_EQ_RESULT = 8'h3c;

    // Reset values
    localparam logic [7:0] RSV_RST_CH2_LINK_STATUS = 8'h01;
    localparam logic [7:0] RSV_RST_OUTPUT_LEVEL = 8'hc0;
    localparam logic [7:0] RSV_RST_EQ_RESULT = 8'h00;

    // Field positions in the second channel link status register
    localparam int RSV_BIT_FAST_EQ_LONG = 7;
    localparam int RSV_BIT_COMPLIANCE = 3;
    localparam int RSV_BIT_ACTIVE = 2;
    localparam int RSV_BIT_LOW_POWER = 1;
    localparam int RSV_BIT_DISCONNECT = 0;

    // Field positions in the output level register
    localparam int RSV_LFPS_LSB = 6;
    localparam int RSV_CONN_LSB = 2;
    localparam int RSV_HOST_LSB = 0;
    localparam int RSV_LEVEL_W = 2;

    // Equalizer code width and channel count
    localparam int RSV_EQ_W = 4;
    localparam int RSV_NUM_CH = 2;

    // Algorithm select bit that must be zero for the fast result flag
    localparam int RSV_ALG_SEL_BIT = 0;

    // Linearity levels, 0 highest through 3 lowest
    typedef enum logic [1:0] {
        RSV_LIN_HIGHEST = 2'h0,
        RSV_LIN_SECOND = 2'h1,
        RSV_LIN_THIRD = 2'h2,
        RSV_LIN_LOWEST = 2'h3
    } rsv_level_type;

    // Link-state events of the second channel from the training logic
    typedef struct packed {
        logic compliance;     // Level: channel is in compliance mode
        logic enter_active;   // Pulse: link entered U0
        logic enter_low_pwr;  // Pulse: link entered U2 or U3
        logic enter_disc;     // Pulse: link entered Disconnect
    } rsv_link_evt_type;

    // Equalizer results of one channel from the adaptive engine
    typedef struct packed {
        logic full_done;               // Pulse: full run finished
        logic fast_applied;            // Pulse: fast run applied a code
        logic fast_long;               // Fast run chose long channel
        logic [RSV_EQ_W-1:0] code;     // Code with the pulses above
    } rsv_eq_evt_type;

    // Linearity settings handed to the transmit drivers
    typedef struct packed {
        rsv_level_type lfps;
        rsv_level_type connector;
        rsv_level_type host;
    } rsv_levels_type;

endpackage

`default_nettype wire

// ==== tb/rsv_regs_assertions.sv ====
// Purpose: Port checks on the status and output-level register group.
// Assumes: Events are one-cycle pulses and every output is registered.
// Notes:   Latencies are the ones the block hands over at its ports.
`default_nettype none
module rsv_chk (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    // Configuration port
    input wire logic [7:0] i_cfg_addr,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_wdata,
    input wire logic [7:0] o_cfg_rdata,
    input wire logic o_cfg_rvalid,
    input wire logic o_cfg_hit,
    // Eq control and events
    input wire logic i_adaptive_eq_enable,
    input wire logic i_eq_override_enable,
    input wire logic [rsv_pkg::RSV_EQ_W-1:0] i_eq_override_value,
    input wire rsv_pkg::rsv_link_evt_type i_ch2_link,
    input wire rsv_pkg::rsv_eq_evt_type i_ch1_eq,
    // Outputs
    input wire rsv_pkg::rsv_levels_type o_levels,
    input wire logic [7:0] o_ch2_link_status,
    input wire logic [rsv_pkg::RSV_EQ_W-1:0] o_ch1_chosen_eq_code
);
    import rsv_pkg::*;
    logic mapped;

    // One clock domain, so one clocking and one disable for all
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    // Offsets that answer on the configuration port
    assign mapped = i_cfg_addr inside {RSV_OFS_CH2_LINK_STATUS,
        RSV_OFS_OUTPUT_LEVEL, RSV_OFS_CH1_EQ_RESULT, RSV_OFS_CH2_EQ_RESULT};

    // A lone state entry shows on the status copy two edges later
    sequence s_entry(logic [2:0] e);
        i_ch2_link[2:0] == e;
    endsequence
    property p_enter_active;
        s_entry(3'b100) |-> ##2 o_ch2_link_status[2:0] == 3'b100;
    endproperty
    a_enter_active: assert property (p_enter_active)
        else $error("active flag wrong after entry");
    property p_enter_low;
        s_entry(3'b010) |-> ##2 o_ch2_link_status[2:0] == 3'b010;
    endproperty
    a_enter_low: assert property (p_enter_low)
        else $error("low power flag wrong after entry");
    property p_enter_disc;
        s_entry(3'b001) |-> ##2 o_ch2_link_status[2:0] == 3'b001;
    endproperty
    a_enter_disc: assert property (p_enter_disc)
        else $error("disconnect flag wrong after entry");

    // Compliance is a level; skip edges that still see reset
    property p_compliance;
        $past(i_rst_n, 2) |->
            o_ch2_link_status[3] == $past(i_ch2_link.compliance, 2);
    endproperty
    a_compliance: assert property (p_compliance)
        else $error("compliance flag does not follow mode");

    // Eq off for three edges clears the long-channel flag
    sequence s_eq_off;
        !i_adaptive_eq_enable [*3];
    endsequence
    property p_eq_off;
        s_eq_off |-> !o_ch2_link_status[7];
    endproperty
    a_eq_off: assert property (p_eq_off)
        else $error("long flag set while eq disabled");

    property p_unmapped;
        i_cfg_rd && !mapped |-> ##1 o_cfg_rvalid && !o_cfg_hit
            && o_cfg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not answered with zero");

    // Reserved bits 5-4 never reach the drivers
    property p_levels;
        logic [7:0] d;
        (i_cfg_wr && i_cfg_addr == RSV_OFS_OUTPUT_LEVEL, d = i_cfg_wdata)
            |-> ##2 o_levels == {d[7:6], d[3:0]};
    endproperty
    a_levels: assert property (p_levels)
        else $error("level fields not passed to drivers");

    property p_full;
        logic [3:0] c;
        (i_ch1_eq.full_done && !i_eq_override_enable, c = i_ch1_eq.code)
            |-> ##3 o_ch1_chosen_eq_code == c;
    endproperty
    a_full: assert property (p_full)
        else $error("full run code not reported");

    property p_override;
        (i_eq_override_enable && $stable(i_eq_override_value)) [*5]
            |-> o_ch1_chosen_eq_code == i_eq_override_value;
    endproperty
    a_override: assert property (p_override)
        else $error("override value not reported");
endmodule

bind rsv_regs rsv_chk u_rsv_chk (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_cfg_addr(i_cfg_addr),
    .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd), .i_cfg_wdata(i_cfg_wdata),
    .o_cfg_rdata(o_cfg_rdata), .o_cfg_rvalid(o_cfg_rvalid),
    .o_cfg_hit(o_cfg_hit), .i_adaptive_eq_enable(i_adaptive_eq_enable),
    .i_eq_override_enable(i_eq_override_enable),
    .i_eq_override_value(i_eq_override_value), .i_ch2_link(i_ch2_link),
    .i_ch1_eq(i_ch1_eq), .o_levels(o_levels),
    .o_ch2_link_status(o_ch2_link_status),
    .o_ch1_chosen_eq_code(o_ch1_chosen_eq_code)
);
`default_nettype wire

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the status and level register group.
// Assumes: Plain strobe port; reads answer on the edge after the strobe.
// Notes:   Inputs change on rising edges by non-blocking assignment.
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rsv_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wr = 1'b0, rd = 1'b0, aen = 1'b0, oen = 1'b0;
    logic lim = 1'b0, lfps = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic [1:0] asel = 2'h0;
    logic [3:0] ovr = 4'h0;
    rsv_link_evt_type lnk = '0;
    rsv_eq_evt_type eq1 = '0, eq2 = '0;
    logic [7:0] rdata;
    logic rvalid, hit;
    logic [3:0] conh, hosth;
    logic [1:0] swing;
    logic limo;
    logic [3:0] c2code;
    rsv_levels_type lv;
    int err_total = 0, checked = 0, cyc = 0;

    rsv_regs DUT (
        .i_sys_clk(clk), .i_rst_n(rst_n), .i_cfg_addr(addr),
        .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_wdata(wdata),
        .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .o_cfg_hit(hit),
        .i_adaptive_eq_enable(aen),
        .i_adaptive_eq_algorithm_select(asel),
        .i_eq_override_enable(oen), .i_eq_override_value(ovr),
        .i_ch2_link(lnk), .i_ch1_eq(eq1), .i_ch2_eq(eq2),
        .i_host_tx_limiting_enable(lim), .i_lfps_active(lfps),
        .o_levels(lv), .o_connector_level_onehot(conh),
        .o_host_level_onehot(hosth), .o_host_tx_limiting(limo),
        .o_host_swing_level(swing), .o_ch2_link_status(),
        .o_ch1_chosen_eq_code(), .o_ch2_chosen_eq_code(c2code)
    );

    // 100 MHz clock
    initial begin
        forever #5 clk = ~clk;
    end

    // Verdict and end of run
    task automatic close_out();
        if (err_total == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One compare for every result, widened to ten bits
    task automatic chk(input string n, input logic [9:0] e,
        input logic [9:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read and compare exactly one edge after the strobe
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        logic h;
        h = a inside {RSV_OFS_CH2_LINK_STATUS, RSV_OFS_OUTPUT_LEVEL,
            RSV_OFS_CH1_EQ_RESULT, RSV_OFS_CH2_EQ_RESULT};
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk($sformatf("reg %h", a), {1'b1, h, e}, {rvalid, hit, rdata});
    endtask

    // Pulses drop after one cycle; compliance stays as a level
    task automatic lnk_evt(input rsv_link_evt_type v);
        @(posedge clk);
        lnk <= v;
        @(posedge clk);
        lnk <= v & 4'h8;
    endtask

    task automatic eq_evt(input logic two, input rsv_eq_evt_type v);
        @(posedge clk);
        if (two) begin
            eq2 <= v;
        end else begin
            eq1 <= v;
        end
        @(posedge clk);
        eq1 <= '0;
        eq2 <= '0;
    endtask

    // Change drive mode, then let the registered copies settle
    task automatic set_drv(input logic f, input logic m);
        @(posedge clk);
        lfps <= f;
        lim <= m;
        repeat (4) @(posedge clk);
        #1;
    endtask

    // Hang guard; the whole sequence needs well under this
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total++;
            close_out();
        end
    end

    // Main sequence
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(RSV_OFS_CH2_LINK_STATUS, 8'h01);
        rd_reg(RSV_OFS_OUTPUT_LEVEL, 8'hc0);
        rd_reg(RSV_OFS_CH1_EQ_RESULT, 8'h00);
        rd_reg(RSV_OFS_CH2_EQ_RESULT, 8'h00);
        rd_reg(8'h26, 8'h00);
        wr_reg(RSV_OFS_OUTPUT_LEVEL, 8'hff);
        rd_reg(RSV_OFS_OUTPUT_LEVEL, 8'hcf);
        wr_reg(RSV_OFS_CH2_LINK_STATUS, 8'hfe);
        rd_reg(RSV_OFS_CH2_LINK_STATUS, 8'h01);
        // Every level code on each driver, LFPS and limiting modes too
        for (int l = 0; l < 4; l++) begin
            wr_reg(RSV_OFS_OUTPUT_LEVEL,
                {2'(3 - l), 2'h0, 2'(l), 2'(l)});
            set_drv(1'b0, 1'b0);
            chk("levels", {4'h0, 2'(3 - l), 2'(l), 2'(l)},
                {4'h0, lv});
            chk("drive", {4'h8 >> l, 4'h8 >> l, 2'h0},
                {conh, hosth, swing});
            chk("limit out", 10'h0, {9'h0, limo});
            set_drv(1'b1, 1'b0);
            chk("lfps", {4'h8 >> (3 - l), 4'h8 >> (3 - l), 2'h0},
                {conh, hosth, swing});
            set_drv(1'b0, 1'b1);
            chk("limit", {4'h8 >> l, 4'h0, 2'(l)},
                {conh, hosth, swing});
            chk("limit out", 10'h1, {9'h0, limo});
        end
        // LFPS still wins in limiting mode; bits 1-0 stay the swing
        set_drv(1'b1, 1'b1);
        chk("lfps limit", {4'h8, 4'h8, 2'h3},
            {conh, hosth, swing});
        // Each state entry clears the other two flags
        for (int i = 0; i < 3; i++) begin
            lnk_evt({1'(i < 2), 3'b100 >> i});
            rd_reg(RSV_OFS_CH2_LINK_STATUS,
                {4'h0, 1'(i < 2), 3'b100 >> i});
        end
        // Full run on channel one, fast long-channel run on two
        eq_evt(1'b0, 7'h49);
        rd_reg(RSV_OFS_CH1_EQ_RESULT, 8'h09);
        @(posedge clk);
        aen <= 1'b1;
        asel <= 2'h2;
        eq_evt(1'b1, 7'h35);
        rd_reg(RSV_OFS_CH2_EQ_RESULT, 8'h05);
        chk("ch2 code", 10'h5, {6'h0, c2code});
        rd_reg(RSV_OFS_CH2_LINK_STATUS, 8'h81);
        @(posedge clk);
        asel <= 2'h1;
        rd_reg(RSV_OFS_CH2_LINK_STATUS, 8'h01);
        @(posedge clk);
        asel <= 2'h0;
        aen <= 1'b0;
        rd_reg(RSV_OFS_CH2_LINK_STATUS, 8'h01);
        // Back on with no new run: the stored flag must have cleared
        @(posedge clk);
        aen <= 1'b1;
        rd_reg(RSV_OFS_CH2_LINK_STATUS, 8'h01);
        // Override shows on both channels; result writes are ignored
        @(posedge clk);
        oen <= 1'b1;
        ovr <= 4'h6;
        repeat (4) @(posedge clk);
        rd_reg(RSV_OFS_CH1_EQ_RESULT, 8'h06);
        wr_reg(RSV_OFS_CH2_EQ_RESULT, 8'hff);
        rd_reg(RSV_OFS_CH2_EQ_RESULT, 8'h06);
        chk("ch2 code", 10'h6, {6'h0, c2code});
        close_out();
    end
endmodule
`default_nettype wire
